// file: logic/flash_status_cfg.svh
// Offsets, field positions, reset values and timing of the status bank.
`ifndef FLASH_STATUS_CFG_SVH
`define FLASH_STATUS_CFG_SVH

// ============================================================
// Register offsets
`define OFS_LOW_BATT_TIMER_CFG 8'h0e
`define OFS_WATCHDOG_RESTART   8'h16
`define OFS_FAULT_STATUS       8'h17
`define OFS_EVENT_STATUS       8'h18
`define OFS_DIE_TYPE_ID        8'h1a

// ============================================================
// Field positions
`define POS_THERM_SHORT   7
`define POS_TX_BLANK      6
`define POS_POWER_GOOD    5
`define POS_DIE_OVERTEMP  4
`define POS_THERM_TRIP    3
`define POS_IND_LED       2
`define POS_FLASH_LED_B   1
`define POS_FLASH_LED_A   0
`define POS_LB_REDUCE     7
`define POS_BLANK_ILIM    6
`define POS_WDT_RESTART   0
`define LB_TIME_MSB       1
`define LB_TIME_LSB       0

// ============================================================
// Reset values
`define RST_LOW_BATT_TIMER 2'h0
`define RST_WATCHDOG       1'h0
`define RST_STATUS         8'h00

// ============================================================
// Timing
`define CLK_PERIOD_NS     8.0
`define LB_TIME_SHORT_MS  0.250
`define LB_TIME_LONG_MS   0.500
`define LB_CODE_SHORT     2'h0
`define LB_CODE_LONG      2'h1

`endif

// file: logic/flash_status_pkg.sv
// Types shared by the flash driver status register bank.
package flash_status_pkg;

	// ============================================================
	// Raw fault and event conditions from the analog detectors.
	typedef struct packed {
		logic therm_short;
		logic tx_blank_pin;
		logic power_good_fault;
		logic die_overtemp;
		logic therm_trip;
		logic ind_led_fault;
		logic flash_led_b_fault;
		logic flash_led_a_fault;
		logic low_batt_reduce;
		logic blank_current_limit;
	} fault_in_s;

	// Low-battery reset timer states.
	typedef enum logic [1:0] {
		LB_IDLE = 2'b01,
		LB_HOLD = 2'b10
	} lb_state_e;

endpackage : flash_status_pkg

// file: logic/flash_driver_status_regs.sv
// Status, watchdog restart, timer setting and die type register bank.
`timescale 1ns/100ps
`include "flash_status_cfg.svh"
// Function
// - Two-bit low-battery reset time, 0.25/0.5 ms
// - Writing one restarts watchdog, bit self-clears
// - Fault bit 7 flags thermistor input short
// - Fault bit 6 flags transmit blanking event
// - Fault bit 5 flags power-good window exit
// - Fault bit 4 flags die over-temperature
// - Fault bit 3 flags thermistor threshold trip
// - Fault bits 2:0 flag LED open/short
// - Flags latch, clear on read, re-set
// - Event bit 7 flags low-battery reduction
// - Event bit 6 flags blanking current limit
// - Read-only fixed two-digit BCD die type
// - Low-battery logic acts only when enabled
// - Blanking input gated by enable, polarity

module flash_driver_status_regs
	import flash_status_pkg::*;
#(
	parameter int unsigned LB_CNT_W        = 16,
	parameter int unsigned LB_SHORT_CYCLES =
		int'($ceil(`LB_TIME_SHORT_MS * 1.0e6 / `CLK_PERIOD_NS)),
	parameter int unsigned LB_LONG_CYCLES  =
		int'($ceil(`LB_TIME_LONG_MS * 1.0e6 / `CLK_PERIOD_NS)),
	// Die type code; the value is arbitrary.
	parameter logic [7:0]  DIE_TYPE_ID     = 8'h42
) (
	// Clock, reset and clock enable.
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_ce,
	// Register port from the serial bus engine.
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	input  wire logic [7:0]  i_reg_addr,
	input  wire logic [7:0]  i_reg_wdata,
	output logic      [7:0]  o_reg_rdata,
	output logic             o_reg_rvalid,
	// Settings held in neighbouring control registers.
	input  wire logic        i_low_batt_func_enable,
	input  wire logic        i_tx_blank_input_enable,
	input  wire logic        i_tx_blank_polarity,
	// Raw detector conditions, asynchronous.
	input  wire fault_in_s   i_fault_raw,
	// Controls toward the converter logic.
	output logic             o_watchdog_restart,
	output logic      [1:0]  o_low_batt_reset_time,
	output logic             o_low_batt_reduce_active
);

	// ============================================================
	// Decode

	// True when an access hits the given register offset.
	function automatic logic hit(input logic [7:0] addr,
		input logic [7:0] ofs);
		hit = (addr == ofs);
	endfunction : hit

	logic wr_timer;
	logic wr_wdt;
	logic rd_fault;
	logic rd_event;

	// Write strobes for the timer and watchdog registers, read strobes for the two status registers.
	assign wr_timer = i_reg_wr && hit(i_reg_addr, `OFS_LOW_BATT_TIMER_CFG);
	assign wr_wdt   = i_reg_wr && hit(i_reg_addr, `OFS_WATCHDOG_RESTART);
	assign rd_fault = i_reg_rd && hit(i_reg_addr, `OFS_FAULT_STATUS);
	assign rd_event = i_reg_rd && hit(i_reg_addr, `OFS_EVENT_STATUS);

	// ============================================================
	// Input synchroniser

	fault_in_s sync_a_reg;
	fault_in_s sync_b_reg;

	// Two flip-flops ahead of any use of the detector levels.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sync_a_reg <= '0;
			sync_b_reg <= '0;
		end else if (i_ce) begin
			sync_a_reg <= i_fault_raw;
			sync_b_reg <= sync_a_reg;
		end
	end

	// ============================================================
	// Condition qualification

	logic blank_active;
	logic lb_trigger;
	logic [7:0] fault_cond;
	logic [7:0] event_cond;

	// Blanking counts only when enabled, at the selected level.
	assign blank_active = i_tx_blank_input_enable &&
		(sync_b_reg.tx_blank_pin == i_tx_blank_polarity);
	// Reduction is only recognised with the low-battery function on.
	assign lb_trigger = i_low_batt_func_enable &&
		sync_b_reg.low_batt_reduce;

	// Fault status conditions, one per bit.
	always_comb begin
		fault_cond = 8'h00;
		fault_cond[`POS_THERM_SHORT]  = sync_b_reg.therm_short;
		fault_cond[`POS_TX_BLANK]     = blank_active;
		fault_cond[`POS_POWER_GOOD]   = sync_b_reg.power_good_fault;
		fault_cond[`POS_DIE_OVERTEMP] = sync_b_reg.die_overtemp;
		fault_cond[`POS_THERM_TRIP]   = sync_b_reg.therm_trip;
		fault_cond[`POS_IND_LED]      = sync_b_reg.ind_led_fault;
		fault_cond[`POS_FLASH_LED_B]  = sync_b_reg.flash_led_b_fault;
		fault_cond[`POS_FLASH_LED_A]  = sync_b_reg.flash_led_a_fault;
	end

	// Event status conditions; the unused bits stay zero.
	always_comb begin
		event_cond = 8'h00;
		event_cond[`POS_LB_REDUCE]  = lb_trigger;
		event_cond[`POS_BLANK_ILIM] = blank_active &&
			sync_b_reg.blank_current_limit;
	end

	// ============================================================
	// Sticky status flags

	logic [7:0] fault_reg;
	logic [7:0] event_reg;

	// A read clears the flags, but a live condition sets them again.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			fault_reg <= `RST_STATUS;
		end else if (i_ce) begin
			fault_reg <= (fault_reg & ~{8{rd_fault}}) | fault_cond;
		end
	end

	// Same latch and clear-on-read behaviour for the event flags.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			event_reg <= `RST_STATUS;
		end else if (i_ce) begin
			event_reg <= (event_reg & ~{8{rd_event}}) | event_cond;
		end
	end

	// ============================================================
	// Writable registers

	logic wdt_bit_reg;

	// Only the timer field is stored; upper bits are dropped.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_low_batt_reset_time <= `RST_LOW_BATT_TIMER;
		end else if (i_ce && wr_timer) begin
			o_low_batt_reset_time <=
				i_reg_wdata[`LB_TIME_MSB:`LB_TIME_LSB];
		end
	end

	// The restart bit stands one cycle, then clears; the restart pulse follows it one cycle later.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wdt_bit_reg        <= `RST_WATCHDOG;
			o_watchdog_restart <= 1'b0;
		end else if (i_ce) begin
			wdt_bit_reg        <= wr_wdt && i_reg_wdata[`POS_WDT_RESTART];
			o_watchdog_restart <= wdt_bit_reg;
		end
	end

	// ============================================================
	// Low-battery reset timer

	lb_state_e           lb_state_reg;
	logic [LB_CNT_W-1:0] lb_cnt_reg;
	logic [LB_CNT_W-1:0] lb_load;

	// Reserved codes fall back to the short time.
	assign lb_load = (o_low_batt_reset_time == `LB_CODE_LONG) ?
		LB_CNT_W'(LB_LONG_CYCLES - 1) :
		LB_CNT_W'(LB_SHORT_CYCLES - 1);

	// Holds reduction active for the set time after the last trigger.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			lb_state_reg <= LB_IDLE;
			lb_cnt_reg   <= '0;
		end else if (i_ce) begin
			if (!i_low_batt_func_enable) begin
				lb_state_reg <= LB_IDLE;
				lb_cnt_reg   <= '0;
			end else if (lb_trigger) begin
				lb_state_reg <= LB_HOLD;
				lb_cnt_reg   <= lb_load;
			end else begin
				case (lb_state_reg)
					LB_IDLE: begin
						lb_cnt_reg <= '0;
					end
					LB_HOLD: begin
						if (lb_cnt_reg == '0) begin
							lb_state_reg <= LB_IDLE;
						end else begin
							lb_cnt_reg <= lb_cnt_reg - 1'b1;
						end
					end
					default: begin
						lb_state_reg <= LB_IDLE;
						lb_cnt_reg   <= '0;
					end
				endcase
			end
		end
	end

	// Reduction output follows the timer state, one cycle later.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_low_batt_reduce_active <= 1'b0;
		end else if (i_ce) begin
			o_low_batt_reduce_active <= (lb_state_reg == LB_HOLD);
		end
	end

	// ============================================================
	// Read data

	// Registered read answer; unmapped offsets read zero.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_reg_rdata  <= 8'h00;
			o_reg_rvalid <= 1'b0;
		end else if (i_ce) begin
			o_reg_rvalid <= i_reg_rd;
			if (i_reg_rd) begin
				if (hit(i_reg_addr, `OFS_LOW_BATT_TIMER_CFG)) begin
					o_reg_rdata <= {6'h00, o_low_batt_reset_time};
				end else if (hit(i_reg_addr, `OFS_WATCHDOG_RESTART)) begin
					o_reg_rdata <= {7'h00, wdt_bit_reg};
				end else if (rd_fault) begin
					o_reg_rdata <= fault_reg;
				end else if (rd_event) begin
					o_reg_rdata <= event_reg;
				end else if (hit(i_reg_addr, `OFS_DIE_TYPE_ID)) begin
					o_reg_rdata <= DIE_TYPE_ID;
				end else begin
					o_reg_rdata <= 8'h00;
				end
			end
		end
	end

endmodule : flash_driver_status_regs

// file: test/flash_status_sva.sv
// Assertion checker for the flash driver status register bank.
`timescale 1ns/100ps
// ============================================================
// Checker
module flash_status_sva
	import flash_status_pkg::*;
#(
	parameter logic [7:0] DIE_TYPE_ID = 8'h42
) (
	// Clock, reset and register port.
	input wire logic       i_clk,
	input wire logic       i_rst,
	input wire logic       i_ce,
	input wire logic       i_reg_wr,
	input wire logic       i_reg_rd,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic [7:0] o_reg_rdata,
	input wire logic       o_reg_rvalid,
	// Settings, detectors and controls.
	input wire logic       i_low_batt_func_enable,
	input wire logic       i_tx_blank_input_enable,
	input wire logic       i_tx_blank_polarity,
	input wire fault_in_s  i_fault_raw,
	input wire logic       o_watchdog_restart,
	input wire logic [1:0] o_low_batt_reset_time,
	input wire logic       o_low_batt_reduce_active
);
	logic rd_any;
	logic rd_flt;
	logic wr_wdt;
	logic quiet;
	logic [1:0] wd_time;
	// Decoded strobes and an all-fault-detectors-idle flag.
	assign rd_any = i_ce && i_reg_rd;
	assign wd_time = i_reg_wdata[1:0];
	assign rd_flt = rd_any && i_reg_addr == 8'h17;
	assign wr_wdt = i_ce && i_reg_wr && i_reg_addr == 8'h16 && i_reg_wdata[0];
	assign quiet = {i_fault_raw[9], i_fault_raw[7:2]} == 7'h00 &&
		(!i_tx_blank_input_enable || i_fault_raw[8] != i_tx_blank_polarity);

	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);

	a_read_answer: assert property (rd_any |=> o_reg_rvalid)
		else $error("read got no answer");
	a_timer_field: assert property (i_ce && i_reg_wr && i_reg_addr == 8'h0e
		|=> o_low_batt_reset_time == $past(wd_time))
		else $error("timer field wrong");
	a_wdt_pulse: assert property (wr_wdt |=> ##1 o_watchdog_restart)
		else $error("restart pulse missing");
	a_wdt_cause: assert property (o_watchdog_restart |-> $past(wr_wdt, 2))
		else $error("restart pulse without write");
	a_wdt_reserved: assert property (rd_any && i_reg_addr == 8'h16
		|=> o_reg_rdata[7:1] == 7'h00) else $error("reserved bits set");
	a_event_reserved: assert property (rd_any && i_reg_addr == 8'h18
		|=> o_reg_rdata[5:0] == 6'h00) else $error("event reserved set");
	a_die_type: assert property (rd_any && i_reg_addr == 8'h1a
		|=> o_reg_rdata == DIE_TYPE_ID) else $error("die type wrong");
	a_overtemp_flag: assert property ((i_ce && i_fault_raw.die_overtemp)[*4]
		##1 rd_flt |=> o_reg_rdata[4]) else $error("overtemp flag lost");
	a_clear_read: assert property (quiet[*4] ##0 rd_flt ##1 quiet[*2]
		##0 rd_flt |=> o_reg_rdata == 8'h00) else $error("flags not cleared");
	a_lb_off: assert property ((!i_low_batt_func_enable)[*4]
		|-> !o_low_batt_reduce_active) else $error("reduction while off");

	c_restart: cover property (o_watchdog_restart);
	c_reduce: cover property (o_low_batt_reduce_active);
	c_flag_read: cover property (o_reg_rvalid && o_reg_rdata != 8'h00);
endmodule : flash_status_sva

bind flash_driver_status_regs flash_status_sva #(.DIE_TYPE_ID(DIE_TYPE_ID))
	u_sva (.*);

// file: test/host_model.sv
// Host processor model that polls the bank through its strobe port.
`timescale 1ns/100ps
// ============================================================
// Host
module host_model (
	// Clock.
	input  wire logic       i_clk,
	// Register port toward the bank.
	output logic            o_wr,
	output logic            o_rd,
	output logic      [7:0] o_addr,
	output logic      [7:0] o_wdata,
	input  wire logic [7:0] i_rdata,
	input  wire logic       i_rvalid
);
	// Strobes idle low from time zero.
	initial begin
		{o_wr, o_rd, o_addr, o_wdata} = 18'h00000;
	end
	// One write pulse; address and data are scrambled once released.
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge i_clk);
		{o_wr, o_addr, o_wdata} = {1'b1, a, v};
		@(negedge i_clk);
		{o_wr, o_addr, o_wdata} = {1'b0, ~a, ~v};
	endtask : wr
	// One read pulse; the answer is taken while rvalid stands.
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(negedge i_clk);
		{o_rd, o_addr} = {1'b1, a};
		@(negedge i_clk);
		v = i_rvalid ? i_rdata : 8'hxx;
		{o_rd, o_addr} = {1'b0, ~a};
	endtask : rd
endmodule : host_model

// file: test/flash_driver_status_regs_bench.sv
// Self-checking bench for the flash driver status register bank.
`timescale 1ns/100ps
// ============================================================
// Bench
module flash_driver_status_regs_bench
	import flash_status_pkg::*;
;
	logic i_clk, i_rst, i_ce, i_reg_wr, i_reg_rd, o_reg_rvalid;
	logic i_low_batt_func_enable, i_tx_blank_input_enable;
	logic i_tx_blank_polarity, o_watchdog_restart, o_low_batt_reduce_active;
	logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, d;
	logic [1:0] o_low_batt_reset_time;
	fault_in_s i_fault_raw;
	int err_count, n_checks, cyc;

	// Short timer counts; the die type value is arbitrary.
	flash_driver_status_regs #(.LB_SHORT_CYCLES(8), .LB_LONG_CYCLES(16),
		.DIE_TYPE_ID(8'h37)) dut (.*);
	host_model host (.i_clk, .o_wr(i_reg_wr), .o_rd(i_reg_rd),
		.o_addr(i_reg_addr), .o_wdata(i_reg_wdata), .i_rdata(o_reg_rdata),
		.i_rvalid(o_reg_rvalid));

	task automatic check(input string n, input logic [7:0] s, e);
		n_checks++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask : check
	task automatic rc(input logic [7:0] a, e, input string n);
		host.rd(a, d);
		check(n, d, e);
	endtask : rc
	task automatic w(input int n);
		repeat (n) @(negedge i_clk);
	endtask : w
	task automatic summarize;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : summarize

	// Reset values, identity, unmapped place and every timer code.
	task automatic t_regs;
		host.wr(8'h1a, 8'h00);
		rc(8'h16, 8'h00, "wdt");
		rc(8'h1a, 8'h37, "id");
		rc(8'h00, 8'h00, "unmapped");
		rc(8'h0e, 8'h00, "timer");
		for (int c = 0; c < 4; c++) begin
			host.wr(8'h0e, 8'hfc | 8'(c));
			check("time", {6'h00, o_low_batt_reset_time}, 8'(c));
			rc(8'h0e, 8'(c), "timer");
		end
	endtask : t_regs
	// Watchdog restart pulses once and the bit clears itself.
	task automatic t_wdt;
		host.wr(8'h16, 8'h01);
		for (int k = 0; k < 4 && o_watchdog_restart !== 1'b1; k++) w(1);
		check("restart", {7'h00, o_watchdog_restart}, 8'h01);
		rc(8'h16, 8'h00, "wdt");
		// A write with the clock enable low must leave the field alone.
		i_ce = 1'b0;
		host.wr(8'h0e, 8'h00);
		check("frozen", {6'h00, o_low_batt_reset_time}, 8'h03);
		i_ce = 1'b1;
	endtask : t_wdt
	// Reduction hold after the trigger drops: setting plus three cycles.
	task automatic t_timer;
		int n;
		for (int c = 0; c < 2; c++) begin
			host.wr(8'h0e, 8'(c));
			i_fault_raw.low_batt_reduce = 1'b1;
			w(6);
			i_fault_raw.low_batt_reduce = 1'b0;
			n = 0;
			while (o_low_batt_reduce_active === 1'b1 && n < 40) begin
				w(1);
				n++;
			end
			check("hold", 8'(n), (c == 1) ? 8'h13 : 8'h0b);
		end
	endtask : t_timer
	// Each fault latches and clears on read; die over-temperature sets again while present.
	task automatic t_flags;
		for (int b = 0; b < 8; b++) begin
			w(1);
			i_fault_raw[b + 2] = 1'b1;
			w(4);
			i_fault_raw[b + 2] = 1'b0;
			w(4);
			rc(8'h17, 8'h01 << b, "fault");
			rc(8'h17, 8'h00, "cleared");
		end
		i_fault_raw.die_overtemp = 1'b1;
		w(5);
		rc(8'h17, 8'h10, "held");
		rc(8'h17, 8'h10, "held");
		i_fault_raw.die_overtemp = 1'b0;
		w(4);
		rc(8'h17, 8'h10, "latched");
		rc(8'h17, 8'h00, "cleared");
	endtask : t_flags
	// Gating by enables and polarity, then both events.
	task automatic t_events;
		{i_tx_blank_input_enable, i_tx_blank_polarity} = 2'b00;
		i_fault_raw[1:0] = 2'b11;
		w(6);
		rc(8'h17, 8'h00, "blank_off");
		rc(8'h18, 8'h00, "gated");
		i_low_batt_func_enable = 1'b1;
		w(5);
		check("reduce", {7'h00, o_low_batt_reduce_active}, 8'h01);
		rc(8'h18, 8'h80, "event");
		i_tx_blank_input_enable = 1'b1;
		i_fault_raw.low_batt_reduce = 1'b0;
		w(4);
		i_fault_raw[8] = 1'b1;
		i_fault_raw.blank_current_limit = 1'b0;
		w(4);
		rc(8'h17, 8'h40, "blank");
		rc(8'h18, 8'hc0, "event");
	endtask : t_events

	// Clock of 8 ns.
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end
	// Cycle ceiling against a hang.
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			summarize();
		end
	end
	// Main sequence.
	initial begin
		{i_rst, i_ce, i_low_batt_func_enable} = 3'b110;
		{i_tx_blank_input_enable, i_tx_blank_polarity} = 2'b11;
		i_fault_raw = '0;
		repeat (5) @(posedge i_clk);
		w(1);
		i_rst = 1'b0;
		t_regs();
		t_wdt();
		t_flags();
		t_events();
		t_timer();
		summarize();
	end
endmodule : flash_driver_status_regs_bench
